// ===== inc/pss_pkg.sv
package pss_pkg;

  // ******************************************************************
  // Variant defaults
  // ******************************************************************
  localparam int PSS_PCW_DEF   = 12;   // Counter width: 10, 11 or 12
  localparam int PSS_DEPTH_DEF = 8;    // Return stack levels: 4 or 8
  localparam int PSS_IW_DEF    = 16;   // Instruction word width

  // ******************************************************************
  // Vectors and reset values
  // ******************************************************************
  localparam logic [11:0] PSS_RESET_VECTOR = 12'h000;
  localparam logic [11:0] PSS_INT_VECTOR   = 12'h004;
  localparam logic [7:0]  PSS_ACC_RESET    = 8'h00;
  localparam logic [15:0] PSS_NOP_WORD     = 16'h0000;

  // ******************************************************************
  // Register port offsets
  // ******************************************************************
  localparam logic [7:0] PSS_REG_PCL    = 8'h00;
  localparam logic [7:0] PSS_REG_STATUS = 8'h01;
  localparam logic [7:0] PSS_REG_ACC    = 8'h02;

  // ******************************************************************
  // Instruction word fields
  // ******************************************************************
  localparam int PSS_OPC_LSB  = 12;
  localparam int PSS_FUNC_LSB = 8;

  // Opcodes
  localparam logic [3:0] PSS_OP_NOP  = 4'h0;
  localparam logic [3:0] PSS_OP_ALU  = 4'h1;
  localparam logic [3:0] PSS_OP_SKZ  = 4'h2;
  localparam logic [3:0] PSS_OP_LDI  = 4'h3;
  localparam logic [3:0] PSS_OP_JMP  = 4'h4;
  localparam logic [3:0] PSS_OP_CALL = 4'h5;
  localparam logic [3:0] PSS_OP_RET  = 4'h6;
  localparam logic [3:0] PSS_OP_INTERRUPT_RETURN_INSTR = 4'h7;
  localparam logic [3:0] PSS_OP_WPCL = 4'h8;
  localparam logic [3:0] PSS_OP_RPCL = 4'h9;

  // Arithmetic unit functions
  localparam logic [3:0] PSS_FN_ADD = 4'h0;
  localparam logic [3:0] PSS_FN_ADC = 4'h1;
  localparam logic [3:0] PSS_FN_SUB = 4'h2;
  localparam logic [3:0] PSS_FN_SBC = 4'h3;
  localparam logic [3:0] PSS_FN_AND = 4'h4;
  localparam logic [3:0] PSS_FN_OR  = 4'h5;
  localparam logic [3:0] PSS_FN_XOR = 4'h6;
  localparam logic [3:0] PSS_FN_CPL = 4'h7;
  localparam logic [3:0] PSS_FN_RL  = 4'h8;
  localparam logic [3:0] PSS_FN_RLC = 4'h9;
  localparam logic [3:0] PSS_FN_RR  = 4'ha;
  localparam logic [3:0] PSS_FN_RRC = 4'hb;
  localparam logic [3:0] PSS_FN_INC = 4'hc;
  localparam logic [3:0] PSS_FN_DEC = 4'hd;
  localparam logic [3:0] PSS_FN_DAA = 4'he;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pss_phase_type;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pss_status_type;

  localparam pss_status_type PSS_STATUS_RESET = 4'h0;

  typedef struct packed {
    logic [7:0]     res;
    pss_status_type st;
  } pss_alu_res_type;

endpackage

// ===== rtl/pss_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Return stack storage, registered read
// ********************************************************************
module pss_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             core_clk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on storage; the level count tells which entries are live
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ===== rtl/pss_sequencer.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pss_sequencer
  import pss_pkg::*;
#(
  parameter int PCW   = PSS_PCW_DEF,
  parameter int DEPTH = PSS_DEPTH_DEF,
  parameter int IW    = PSS_IW_DEF
) (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst,
  // Program memory
  output logic      [PCW-1:0] prog_addr,
  input  wire logic [IW-1:0]  prog_data,
  // Interrupt logic
  input  wire logic           int_req,
  input  wire logic           int_enable,
  output logic                int_ack,
  output logic                int_return,
  // Register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  // Phase and state
  output logic      [3:0]     instruction_phase_clocks,
  output logic                stack_full
);

  // ******************************************************************
  // Local sizes
  // ******************************************************************
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] TOP_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   LVL_FULL = (AW + 1)'(DEPTH);

  // ******************************************************************
  // Arithmetic helpers
  // ******************************************************************

  // Nine-bit add with carry in, used by add, subtract, inc and dec
  function automatic logic [8:0] add9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Carry out of the low nibble
  function automatic logic nib_carry(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic       cin);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    nib_carry = s[4];
  endfunction

  // Eight-bit unit; carry set means no borrow on subtract
  function automatic pss_alu_res_type alu(input logic [3:0]     fn,
                                          input logic [7:0]     a,
                                          input logic [7:0]     b,
                                          input pss_status_type st);
    pss_alu_res_type r;
    logic [7:0]      bb;
    logic            cin;
    logic [8:0]      s;
    logic [8:0]      d;
    r     = '{res: 8'h00, st: st};
    bb    = b;
    cin   = 1'b0;
    s     = 9'h000;
    d     = {1'b0, a};
    case (fn)
      PSS_FN_ADD, PSS_FN_ADC, PSS_FN_SUB, PSS_FN_SBC: begin
        bb   = (fn == PSS_FN_SUB || fn == PSS_FN_SBC) ? ~b : b;
        cin  = (fn == PSS_FN_ADD) ? 1'b0 : (fn == PSS_FN_SUB) ? 1'b1 : st.c;
        s    = add9(a, bb, cin);
        r.res = s[7:0];
        r.st.c  = s[8];
        r.st.ac = nib_carry(a, bb, cin);
        r.st.ov = (a[7] == bb[7]) && (s[7] != a[7]);
      end
      PSS_FN_AND: r.res = a & b;
      PSS_FN_OR:  r.res = a | b;
      PSS_FN_XOR: r.res = a ^ b;
      PSS_FN_CPL: r.res = ~a;
      PSS_FN_RL:  r.res = {a[6:0], a[7]};
      PSS_FN_RR:  r.res = {a[0], a[7:1]};
      PSS_FN_RLC: begin
        r.res  = {a[6:0], st.c};
        r.st.c = a[7];
      end
      PSS_FN_RRC: begin
        r.res  = {st.c, a[7:1]};
        r.st.c = a[0];
      end
      PSS_FN_INC: begin
        s     = add9(a, 8'h01, 1'b0);
        r.res = s[7:0];
      end
      PSS_FN_DEC: begin
        s     = add9(a, 8'hff, 1'b0);
        r.res = s[7:0];
      end
      PSS_FN_DAA: begin
        // Carry only ever sets here, it is never cleared by the adjust
        if (a[3:0] > 4'h9 || st.ac) begin
          d = d + 9'h006;
        end
        if (d[8:4] > 5'h09 || st.c) begin
          d = d + 9'h060;
        end
        r.res  = d[7:0];
        r.st.c = st.c | d[8];
      end
      default: r.res = a;
    endcase
    // Rotates, with or without carry, leave zero alone; all others refresh it
    if (fn != PSS_FN_RL && fn != PSS_FN_RR && fn != PSS_FN_RLC && fn != PSS_FN_RRC) begin
      r.st.z = (r.res == 8'h00);
    end
    alu = r;
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  pss_phase_type    ph_r, ph_nxt;
  logic [PCW-1:0]   pc_r, pc_nxt;
  logic [IW-1:0]    ir_r, ir_nxt;
  logic [7:0]       acc_r, acc_nxt;
  pss_status_type   status_r, status_nxt;
  logic [AW-1:0]    top_r, top_nxt;
  logic [AW:0]      lvl_r, lvl_nxt;
  logic             int_pend_r, int_pend_nxt;
  logic             pcl_pend_r, pcl_pend_nxt;
  logic [7:0]       pcl_val_r, pcl_val_nxt;
  logic             int_ack_r;
  logic             int_ret_r;
  logic [3:0]       phase_r;
  logic [7:0]       rdata_r;
  logic [PCW-1:0]   stk_rdata;

  // ******************************************************************
  // Phase sequencing
  // ******************************************************************

  // INSTRUCTION_PHASE_CLOCKS repeat; the commit edge closes T4
  assign ph_nxt = (ph_r == PH_T4) ? PH_T1 : pss_phase_type'(ph_r + 2'd1);
  wire   commit = (ph_r == PH_T4);

  // ******************************************************************
  // Decode of the word in execution
  // ******************************************************************

  // The word in ir_r was fetched last cycle and executes now
  wire [3:0] opc = ir_r[PSS_OPC_LSB +: 4];
  wire [3:0] fn  = ir_r[PSS_FUNC_LSB +: 4];
  wire [7:0] imm = ir_r[7:0];
  wire [PCW-1:0] target = ir_r[PCW-1:0];

  wire is_alu  = (opc == PSS_OP_ALU) || (opc == PSS_OP_SKZ);
  wire is_jump = (opc == PSS_OP_JMP);
  wire is_call = (opc == PSS_OP_CALL);
  wire is_interrupt_return_instr = (opc == PSS_OP_INTERRUPT_RETURN_INSTR);
  wire is_ret  = (opc == PSS_OP_RET) || is_interrupt_return_instr;
  wire is_wpcl = (opc == PSS_OP_WPCL);
  wire is_rpcl = (opc == PSS_OP_RPCL);
  wire is_ldi  = (opc == PSS_OP_LDI);

  // Accumulator and immediate through the unit
  wire pss_alu_res_type alu_out = alu(fn, acc_r, imm, status_r);

  // Skip decision comes from the unit's zero result
  wire skip_take = (opc == PSS_OP_SKZ) && (alu_out.res == 8'h00);

  // Any instruction that changes the counter other than by the plain increment
  wire branch_instr = is_jump || is_call || is_ret || is_wpcl;

  // ******************************************************************
  // Software low-byte writes
  // ******************************************************************

  // Held until a commit where no branch of its own competes
  wire       bus_wr_pcl = reg_wr && (reg_addr == PSS_REG_PCL);
  wire       pcl_req    = pcl_pend_r || bus_wr_pcl;
  wire [7:0] pcl_val    = bus_wr_pcl ? reg_wdata : pcl_val_r;
  wire       pcl_apply  = commit && pcl_req && !branch_instr;

  assign pcl_pend_nxt = bus_wr_pcl ? !pcl_apply : (pcl_pend_r && !pcl_apply);
  assign pcl_val_nxt  = bus_wr_pcl ? reg_wdata : pcl_val_r;

  // ******************************************************************
  // Interrupt acceptance
  // ******************************************************************

  // Taken only between plain instructions, and never onto a full stack
  wire full     = (lvl_r == LVL_FULL);
  wire int_take = commit && int_pend_r && int_enable && !full
                  && !branch_instr && !skip_take && !pcl_req;

  // Request recorded even while full; a new request beats the clear
  assign int_pend_nxt = int_req || (int_pend_r && !int_take);

  // ******************************************************************
  // Return stack pointer
  // ******************************************************************
  wire push = commit && (is_call || int_take);
  wire pop  = commit && is_ret;

  wire [AW-1:0] top_inc = (top_r == TOP_LAST) ? '0 : top_r + AW'(1);
  wire [AW-1:0] top_dec = (top_r == '0) ? TOP_LAST : top_r - AW'(1);

  // A full push wraps and overwrites the oldest, level stays at depth
  assign top_nxt = push ? top_inc
                 : (pop && lvl_r != '0) ? top_dec
                 : top_r;
  assign lvl_nxt = push ? (full ? lvl_r : lvl_r + (AW + 1)'(1))
                 : (pop && lvl_r != '0) ? lvl_r - (AW + 1)'(1)
                 : lvl_r;

  // Storage has no software path; it sees only counter values
  pss_stack_mem #(
    .DEPTH (DEPTH),
    .WIDTH (PCW),
    .AW    (AW)
  ) u_stack (
    .core_clk (core_clk),
    .wr_en    (push),
    .wr_addr  (top_r),
    .wr_data  (pc_r),
    .rd_addr  (top_dec),
    .rd_data  (stk_rdata)
  );

  // ******************************************************************
  // Next program counter
  // ******************************************************************

  // Page kept on low-byte writes; only eight bits are ever replaced
  wire [PCW-1:0] pc_inc  = pc_r + PCW'(1);
  wire [PCW-1:0] pc_page = {pc_r[PCW-1:8], acc_r};
  wire [PCW-1:0] pc_bus  = {pc_r[PCW-1:8], pcl_val};

  assign pc_nxt = !commit      ? pc_r
                : (is_jump || is_call) ? target
                : is_ret       ? stk_rdata
                : is_wpcl      ? pc_page
                : pcl_apply    ? pc_bus
                : int_take     ? PCW'(PSS_INT_VECTOR)
                : pc_inc;

  // ******************************************************************
  // Prefetch register
  // ******************************************************************

  // Any redirect throws the prefetched word away, giving the dummy cycle
  wire flush = branch_instr || skip_take || pcl_apply || int_take;

  assign ir_nxt = !commit ? ir_r
                : flush   ? IW'(PSS_NOP_WORD)
                : prog_data;

  // ******************************************************************
  // Accumulator and status
  // ******************************************************************

  // Executing instruction wins over a same-cycle software write
  wire bus_wr_acc = reg_wr && (reg_addr == PSS_REG_ACC);

  assign acc_nxt = (commit && is_alu)  ? alu_out.res
                 : (commit && is_ldi)  ? imm
                 : (commit && is_rpcl) ? pc_r[7:0]
                 : bus_wr_acc          ? reg_wdata
                 : acc_r;
  assign status_nxt = (commit && is_alu) ? alu_out.st : status_r;

  // ******************************************************************
  // Register read path
  // ******************************************************************

  // Only the low byte of the counter appears; unmapped reads give zero
  wire [7:0] rd_mux = (reg_addr == PSS_REG_PCL)    ? pc_r[7:0]
                    : (reg_addr == PSS_REG_STATUS) ? {4'h0, status_r}
                    : (reg_addr == PSS_REG_ACC)    ? acc_r
                    : 8'h00;

  // ******************************************************************
  // Registers
  // ******************************************************************

  // Phase and pipeline
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph_r <= PH_T1;
      pc_r <= PCW'(PSS_RESET_VECTOR);
      ir_r <= IW'(PSS_NOP_WORD);
    end else begin
      ph_r <= ph_nxt;
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
    end
  end

  // Data path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_r    <= PSS_ACC_RESET;
      status_r <= PSS_STATUS_RESET;
    end else begin
      acc_r    <= acc_nxt;
      status_r <= status_nxt;
    end
  end

  // Stack pointer, empty after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      top_r <= '0;
      lvl_r <= '0;
    end else begin
      top_r <= top_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // Pending requests
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_pend_r <= 1'b0;
      pcl_pend_r <= 1'b0;
      pcl_val_r  <= 8'h00;
    end else begin
      int_pend_r <= int_pend_nxt;
      pcl_pend_r <= pcl_pend_nxt;
      pcl_val_r  <= pcl_val_nxt;
    end
  end

  // Outputs, one-hot phase follows the phase counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r   <= 4'h1;
      int_ack_r <= 1'b0;
      int_ret_r <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      phase_r   <= 4'h1 << ph_nxt;
      int_ack_r <= int_take;
      int_ret_r <= commit && is_interrupt_return_instr;
      rdata_r   <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ******************************************************************
  // Port drive
  // ******************************************************************
  assign prog_addr                = pc_r;
  assign int_ack                  = int_ack_r;
  assign int_return               = int_ret_r;
  assign reg_rdata                = rdata_r;
  assign instruction_phase_clocks = phase_r;
  assign stack_full               = full;

endmodule

`default_nettype wire

// ===== test/pss_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************
// Sequencer port checker
// ********************************************
module pss_seq_monitor
  import pss_pkg::*;
#(
  parameter int PCW   = PSS_PCW_DEF,
  parameter int DEPTH = PSS_DEPTH_DEF,
  parameter int IW    = PSS_IW_DEF
) (
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rst,
  // Program memory
  input wire logic [PCW-1:0] prog_addr,
  input wire logic [IW-1:0]  prog_data,
  // Interrupt logic
  input wire logic           int_req,
  input wire logic           int_enable,
  input wire logic           int_ack,
  input wire logic           int_return,
  // Register port
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  // Phase and state
  input wire logic [3:0]     instruction_phase_clocks,
  input wire logic           stack_full
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_phase_onehot: assert property ($onehot(instruction_phase_clocks))
    else $error("phase outputs not one-hot");
  // Reset holds T1, and the first edge that samples reset low starts the walk to T2
  chk_phase_order: assert property (instruction_phase_clocks[0] && !rst |=> instruction_phase_clocks[1]
    ##1 instruction_phase_clocks[2] ##1 instruction_phase_clocks[3] ##1 instruction_phase_clocks[0])
    else $error("phase sequence broken");
  // Fetch address moves only at the commit edge
  chk_fetch_hold: assert property (!instruction_phase_clocks[3] |=> $stable(prog_addr))
    else $error("fetch address moved outside commit");
  chk_vector_load: assert property (int_ack |-> instruction_phase_clocks[0]
    && prog_addr == PSS_INT_VECTOR[PCW-1:0]) else $error("acknowledge without vector load");
  chk_ack_pulse: assert property (int_ack |=> !int_ack)
    else $error("acknowledge longer than one cycle");
  chk_full_refuse: assert property (instruction_phase_clocks[3] && stack_full |=> !int_ack)
    else $error("interrupt taken on full stack");
  chk_mask_refuse: assert property (instruction_phase_clocks[3] && !int_enable |=> !int_ack)
    else $error("interrupt taken while disabled");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  chk_hidden_zero: assert property (reg_rd && reg_addr > PSS_REG_ACC |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pcl_read: assert property (reg_rd && reg_addr == PSS_REG_PCL && !instruction_phase_clocks[3]
    |=> reg_rdata == prog_addr[7:0]) else $error("counter low byte read wrong");
  chk_ret_pulse: assert property (int_return |-> instruction_phase_clocks[0] ##1 !int_return)
    else $error("return pulse misplaced");
  // Stack level changes only when an instruction commits
  chk_level_hold: assert property (!instruction_phase_clocks[3] |=> $stable(stack_full))
    else $error("stack level moved outside commit");
endmodule

bind pss_sequencer pss_seq_monitor #(.PCW(PCW), .DEPTH(DEPTH), .IW(IW)) u_mon (
  .core_clk(core_clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
  .int_req(int_req), .int_enable(int_enable), .int_ack(int_ack), .int_return(int_return),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instruction_phase_clocks(instruction_phase_clocks),
  .stack_full(stack_full));

`default_nettype wire

// ===== test/pss_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************
// Program memory with a fixed test program
// ********************************************
module pss_prog_model #(
  parameter int PCW = 12,
  parameter int IW  = 16
) (
  // Fetch port
  input wire logic [PCW-1:0] prog_addr,
  output logic     [IW-1:0]  prog_data
);
  logic [IW-1:0] mem [2**PCW];

  // Word at 0x004 is a return that only an interrupt should reach
  initial begin
    for (int i = 0; i < 2**PCW; i++) mem[i] = '0;
    mem[12'h000] = 16'h3005; mem[12'h001] = 16'h1003; mem[12'h002] = 16'h5010;
    mem[12'h003] = 16'h2208; mem[12'h004] = 16'h7000; mem[12'h005] = 16'h4120;
    mem[12'h010] = 16'h6000; mem[12'h120] = 16'h3040; mem[12'h121] = 16'h8000;
    mem[12'h1a0] = 16'h51b0; mem[12'h1b0] = 16'h51c0; mem[12'h1c0] = 16'h51d0;
    mem[12'h1d0] = 16'h51e0; mem[12'h1e3] = 16'h51f0; mem[12'h1e4] = 16'h6000;
    mem[12'h1f0] = 16'h6000; mem[12'h1d1] = 16'h6000; mem[12'h1c1] = 16'h6000;
    mem[12'h1b1] = 16'h4300;
  end

  // Asynchronous read, always driven
  assign prog_data = mem[prog_addr];
endmodule

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ********************************************
  // Signals
  // ********************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [3:0]  code;
  } pss_tb_row_type;

  logic        core_clk   = 1'b0;
  logic        rst        = 1'b1;
  logic        int_req    = 1'b0;
  logic        int_enable = 1'b0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [7:0]  reg_addr   = 8'h00;
  logic [7:0]  reg_wdata  = 8'h00;
  logic [11:0] prog_addr;
  logic [15:0] prog_data;
  logic        int_ack;
  logic        int_return;
  logic [7:0]  reg_rdata;
  logic [3:0]  instruction_phase_clocks;
  logic        stack_full;
  int          err_total  = 0;
  int          n_tests    = 0;

  // Codes: 1 request, 2 request masked, 3 low byte write, 4 ack due, 5 return due
  pss_tb_row_type rows [47] = '{
    16'h0000, 16'h0010, 16'h0020, 16'h0030, 16'h0100, 16'h0110, 16'h0030, 16'h0040,
    16'h0050, 16'h0060, 16'h1200, 16'h1210, 16'h1220, 16'h1402, 16'h1411, 16'h0044,
    16'h0050, 16'h1415, 16'h1423, 16'h1a00, 16'h1a10, 16'h1b00, 16'h1b10, 16'h1c00,
    16'h1c10, 16'h1d00, 16'h1d10, 16'h1e01, 16'h1e10, 16'h1e20, 16'h1e30, 16'h1e40,
    16'h1f00, 16'h1f10, 16'h1e40, 16'h0044, 16'h0050, 16'h1e45, 16'h1e50, 16'h1d10,
    16'h1d20, 16'h1c10, 16'h1c20, 16'h1b10, 16'h1b20, 16'h3000, 16'h3010};

  // ********************************************
  // Design and program memory
  // ********************************************
  // Four-level variant keeps the overflow walk short
  pss_sequencer #(.PCW(12), .DEPTH(4), .IW(16)) DUT (
    .core_clk(core_clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .int_req(int_req), .int_enable(int_enable), .int_ack(int_ack), .int_return(int_return),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instruction_phase_clocks(instruction_phase_clocks),
    .stack_full(stack_full));

  pss_prog_model #(.PCW(12), .IW(16)) u_pmem (.prog_addr(prog_addr), .prog_data(prog_data));

  // ********************************************
  // Tasks
  // ********************************************
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({11'h000, got}, {11'h000, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk_val({4'h0, reg_rdata & m}, {4'h0, exp & m});
  endtask

  task automatic results();
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ********************************************
  // Clock, watchdog, sequence
  // ********************************************
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    results();
  end

  // Rows give the fetch address at each T1; stimulus lands in T2
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    for (int k = 0; k < 47; k++) begin
      chk_val(prog_addr, rows[k].addr);
      chk_flag(int_ack, rows[k].code == 4'h4);
      chk_flag(int_return, rows[k].code == 4'h5);
      chk_flag(stack_full, (k >= 27 && k <= 33) || k == 35 || k == 36);
      @(posedge core_clk);
      if (rows[k].code == 4'h1 || rows[k].code == 4'h2) begin
        int_req    <= 1'b1;
        int_enable <= (rows[k].code == 4'h1);
      end
      if (rows[k].code == 4'h3) begin
        reg_wr    <= 1'b1;
        reg_wdata <= 8'ha0;
      end
      @(posedge core_clk);
      int_req <= 1'b0;
      reg_wr  <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
    end
    rd(8'h00, 8'h02, 8'hff);
    rd(8'h02, 8'h40, 8'hff);
    rd(8'h01, 8'h05, 8'h0d);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h05, 8'h0d);
    wr(8'h02, 8'h5a);
    rd(8'h02, 8'h5a, 8'hff);
    wr(8'h7f, 8'h33);
    rd(8'h7f, 8'h00, 8'hff);
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_val({8'h00, instruction_phase_clocks}, 12'h001);
    chk_val(prog_addr, 12'h000);
    chk_flag(stack_full, 1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h02, 8'h00, 8'hff);
    results();
  end
endmodule

`default_nettype wire
